// [logic/setc_cfg_if.sv]
`timescale 1ns/1ps
interface setc_cfg_if;
  logic [7:0] mantissa;
  logic [3:0] exponent;
  logic [7:0] protocol;
  logic       tick;
  logic       linkClk;
  modport ctl (output mantissa, output exponent, output protocol, input tick, input linkClk);
  modport gen (input mantissa, input exponent, input protocol, output tick, output linkClk);
endinterface

// [logic/setc_pkg.sv]
// What this block does
// - control word: mantissa divider M in bits 31:24, exponent divider N in 23:20
// - protocol 03: link clock is 4 MHz over (M+1) times two to the N
// - intermediate tick is 100 MHz over (M+1) times two to the N
// - control bit 17 picks the trigger clock: 0 phase, 1 servo
// - control bit 16 picks the trigger edge: 0 rising, 1 falling
// - wait bits 15:8 intermediate ticks, 0 to 255, after the edge before reading
// - bits 7:0 select the protocol; 03 selects the 4 MHz based link clock
// - protocol 0E: built-in encoder, bits 31:18 reserved, no link clock divider
// - control and enable writes are ignored unless the unlock key is held
// - each channel has a link enable bit, reset 0, writing 1 enables
// - the enable bit is bit 20 of the channel input control word
// - each channel has a command word that resets to zero
// - protocol 0B: link clock equals the intermediate tick
package setc_pkg;
  localparam int NCH = 4;
  localparam int DIV_W = 24;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_KEY    = 8'h04;
  localparam logic [7:0] OFF_STAT   = 8'h08;
  localparam logic [7:0] OFF_ENA    = 8'h10;
  localparam logic [7:0] OFF_CHANNEL_INPUT_CONTROL = 8'h20;
  localparam logic [7:0] OFF_CMD    = 8'h30;
  localparam logic [7:0] CH_STRIDE  = 8'h04;

  // reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0F40_0000;
  localparam logic [31:0] CHANNEL_INPUT_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
  localparam logic [31:0] KEY_RESET    = 32'h0000_0000;
  // arbitrary unlock value
  localparam logic [31:0] UNLOCK_KEY   = 32'hC0DE_5A17;

  // field positions
  localparam int MDIV_LSB  = 24;
  localparam int NDIV_LSB  = 20;
  localparam int SRC_BIT   = 17;
  localparam int EDGE_BIT  = 16;
  localparam int DLY_LSB   = 8;
  localparam int PROTO_LSB = 0;
  localparam int ENA_BIT   = 20;
  localparam int STAT_UNLOCK_BIT = 0;
  localparam int STAT_BUSY_LSB   = 4;

  // protocol codes
  localparam logic [7:0] PROTO_DIV4    = 8'h03;
  localparam logic [7:0] PROTO_DIRECT  = 8'h0B;
  localparam logic [7:0] PROTO_BUILTIN = 8'h0E;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_MHZ      = 1000 / CLK_PERIOD_NS;
  localparam int LINK_BASE_MHZ = 4;
  localparam int LINK_TICKS    = BASE_MHZ / LINK_BASE_MHZ;
  localparam int LINK_HIGH     = (LINK_TICKS + 1) / 2;

  typedef enum logic [0:0] {CH_IDLE, CH_WAIT} setc_ch_state_t;
endpackage

// [logic/setc_tick_gen.sv]
`timescale 1ns/1ps
module setc_tick_gen (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // configuration and outputs
  setc_cfg_if.gen  cfg
);
  import setc_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] divCnt;
    logic [4:0]       linkCnt;
    logic             tick;
    logic             linkClk;
  } setc_gen_state_t;

  setc_gen_state_t r;
  setc_gen_state_t n;
  logic [DIV_W-1:0] period;
  logic             wrap;

  assign period  = (DIV_W'(cfg.mantissa) + 24'h000001) << cfg.exponent;
  assign cfg.tick    = r.tick;
  assign cfg.linkClk = r.linkClk;

  always_comb begin
    n = r;
    // >= so a shrinking period never strands the counter
    wrap = (r.divCnt >= period - 24'h000001);
    n.tick = wrap;
    n.divCnt = wrap ? '0 : r.divCnt + 24'h000001;
    if (wrap) begin
      n.linkCnt = (r.linkCnt == 5'(LINK_TICKS - 1)) ? 5'h00 : r.linkCnt + 5'h01;
    end
    case (cfg.protocol)
      PROTO_DIV4:   n.linkClk = (n.linkCnt < 5'(LINK_HIGH));
      PROTO_DIRECT: n.linkClk = (n.divCnt < (period >> 1));
      default:      n.linkClk = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // setc_tick_gen

// [logic/setc_top.sv]
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module setc_top (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        srst,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // trigger clocks
  input  wire logic                        phaseClock,
  input  wire logic                        servoClock,
  // link side
  output logic                             linkClock,
  output logic [setc_pkg::NCH-1:0]         linkEnable,
  output logic [setc_pkg::NCH-1:0]         transferStart,
  output logic [setc_pkg::NCH-1:0][31:0]   linkCommand,
  output logic [7:0]                       protocolSelect
);
  import setc_pkg::*;

  typedef struct packed {
    logic [31:0]                ctrl;
    logic [31:0]                key;
    logic [NCH-1:0][31:0]       channel_input_control;
    logic [NCH-1:0][31:0]       cmd;
    logic                       dataPhase;
    logic                       dataWrite;
    logic [7:0]                 dataAddr;
    logic [31:0]                rdata;
    logic                       readyOut;
    logic                       resp;
    logic                       prevPhase;
    logic                       prevServo;
    setc_ch_state_t [NCH-1:0]   chState;
    logic [NCH-1:0][7:0]        chCnt;
    logic [NCH-1:0]             start;
    logic                       linkClk;
  } setc_top_state_t;

  setc_top_state_t r;
  setc_top_state_t n;
  setc_cfg_if      cfgIf ();

  logic       unlocked;
  logic       curLevel;
  logic       prevLevel;
  logic       edgeHit;
  logic [7:0] delay;

  setc_tick_gen u_tick_gen (
    .clock (clock),
    .srst  (srst),
    .cfg   (cfgIf.gen)
  );

  assign cfgIf.mantissa = r.ctrl[MDIV_LSB +: 8];
  assign cfgIf.exponent = r.ctrl[NDIV_LSB +: 4];
  assign cfgIf.protocol = r.ctrl[PROTO_LSB +: 8];

  assign hreadyout      = r.readyOut;
  assign hresp          = r.resp;
  assign hrdata         = r.rdata;
  assign linkClock      = r.linkClk;
  assign transferStart  = r.start;
  assign linkCommand    = r.cmd;
  assign protocolSelect = r.ctrl[PROTO_LSB +: 8];

  // enable has no storage of its own, so both views always agree
  for (genvar g = 0; g < NCH; g++) begin : g_ena
    assign linkEnable[g] = r.channel_input_control[g][ENA_BIT];
  end

  assign unlocked  = (r.key == UNLOCK_KEY);
  assign curLevel  = r.ctrl[SRC_BIT] ? servoClock : phaseClock;
  assign prevLevel = r.ctrl[SRC_BIT] ? r.prevServo : r.prevPhase;
  assign edgeHit   = r.ctrl[EDGE_BIT] ? (prevLevel & ~curLevel) : (curLevel & ~prevLevel);
  assign delay     = r.ctrl[DLY_LSB +: 8];

  function automatic logic [31:0] readReg(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == OFF_CTRL) begin
      v = r.ctrl;
    end
    if (a == OFF_STAT) begin
      v[STAT_UNLOCK_BIT] = unlocked;
      for (int k = 0; k < NCH; k++) begin
        v[STAT_BUSY_LSB + k] = (r.chState[k] == CH_WAIT);
      end
    end
    for (int k = 0; k < NCH; k++) begin
      if (a == OFF_ENA + 8'(k * 4)) begin
        v[0] = r.channel_input_control[k][ENA_BIT];
      end
      if (a == OFF_CHANNEL_INPUT_CONTROL + 8'(k * 4)) begin
        v = r.channel_input_control[k];
      end
      if (a == OFF_CMD + 8'(k * 4)) begin
        v = r.cmd[k];
      end
    end
    return v;
  endfunction

  always_comb begin
    n = r;
    n.start     = '0;
    n.prevPhase = phaseClock;
    n.prevServo = servoClock;
    n.linkClk   = cfgIf.linkClk;
    n.readyOut  = 1'b1;
    n.resp      = 1'b0;

    // data phase of a write
    if (r.dataPhase && r.dataWrite) begin
      if (r.dataAddr == OFF_KEY) begin
        n.key = hwdata;
      end
      // reserved bits are stored as written; software keeps them zero
      if (r.dataAddr == OFF_CTRL && unlocked) begin
        n.ctrl = hwdata;
      end
      for (int j = 0; j < NCH; j++) begin
        if (r.dataAddr == OFF_ENA + 8'(j * 4) && unlocked) begin
          n.channel_input_control[j][ENA_BIT] = hwdata[0];
        end
        if (r.dataAddr == OFF_CHANNEL_INPUT_CONTROL + 8'(j * 4) && unlocked) begin
          n.channel_input_control[j] = hwdata;
        end
        if (r.dataAddr == OFF_CMD + 8'(j * 4)) begin
          n.cmd[j] = hwdata;
        end
      end
    end

    // address phase; read data is captured here so it stands in the data phase
    n.dataPhase = hsel && hready && htrans[1];
    n.dataWrite = hwrite;
    n.dataAddr  = haddr[7:0];
    n.rdata     = (n.dataPhase && !hwrite) ? readReg(haddr[7:0]) : 32'h0000_0000;

    // per-channel trigger sequencing; an edge while waiting is not queued
    for (int j = 0; j < NCH; j++) begin
      case (r.chState[j])
        CH_IDLE: begin
          if (r.channel_input_control[j][ENA_BIT] && edgeHit) begin
            if (delay == 8'h00) begin
              n.start[j] = 1'b1;
            end else begin
              n.chState[j] = CH_WAIT;
              n.chCnt[j]   = delay;
            end
          end
        end
        CH_WAIT: begin
          if (!r.channel_input_control[j][ENA_BIT]) begin
            n.chState[j] = CH_IDLE;
          end else if (cfgIf.tick) begin
            if (r.chCnt[j] == 8'h01) begin
              n.start[j]   = 1'b1;
              n.chState[j] = CH_IDLE;
            end else begin
              n.chCnt[j] = r.chCnt[j] - 8'h01;
            end
          end
        end
        default: n.chState[j] = CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r          <= '0;
      r.ctrl     <= CTRL_RESET;
      r.key      <= KEY_RESET;
      r.channel_input_control   <= {NCH{CHANNEL_INPUT_CONTROL_RESET}};
      r.cmd      <= {NCH{CMD_RESET}};
      r.readyOut <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // checking helpers: cycles between ticks, and divider changes in between
  logic [DIV_W-1:0] gapCnt;
  logic             seenTick;
  logic             cfgDirty;
  logic             cfgChg;
  logic [DIV_W-1:0] expPeriod;

  assign cfgChg    = (n.ctrl[31:20] != r.ctrl[31:20]);
  assign expPeriod = (DIV_W'(r.ctrl[MDIV_LSB +: 8]) + 24'h000001) << r.ctrl[NDIV_LSB +: 4];

  always_ff @(posedge clock) begin
    if (srst) begin
      gapCnt   <= '0;
      seenTick <= 1'b0;
      cfgDirty <= 1'b1;
    end else if (cfgIf.tick) begin
      gapCnt   <= 24'h000001;
      seenTick <= 1'b1;
      cfgDirty <= cfgChg;
    end else begin
      gapCnt   <= gapCnt + 24'h000001;
      cfgDirty <= cfgDirty | cfgChg;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_tick_period;
    cfgIf.tick && seenTick && !cfgDirty && !cfgChg |-> gapCnt == expPeriod;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong");

  property p_ctrl_locked;
    r.dataPhase && r.dataWrite && r.dataAddr == OFF_CTRL && !unlocked |=> $stable(r.ctrl);
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) else $error("locked ctrl changed");

  property p_ctrl_unlocked;
    r.dataPhase && r.dataWrite && r.dataAddr == OFF_CTRL && unlocked
      |=> r.ctrl == $past(hwdata);
  endproperty
  a_ctrl_unlocked: assert property (p_ctrl_unlocked) else $error("ctrl write lost");

  property p_builtin_no_clock;
    protocolSelect == PROTO_BUILTIN ##1 protocolSelect == PROTO_BUILTIN |=> !linkClock;
  endproperty
  a_builtin_no_clock: assert property (p_builtin_no_clock) else $error("clock in 0E");

  property p_reset_clear;
    srst |=> linkEnable == '0 && linkCommand == '0 && transferStart == '0;
  endproperty
  a_reset_clear: assert property (disable iff (1'b0) p_reset_clear)
    else $error("reset values wrong");

  // a refused write still answers okay, so software sees no bus error
  property p_bus_okay;
    r.dataPhase |-> hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response not okay");

  property p_tick_single;
    cfgIf.tick && expPeriod != 24'h000001 |=> !cfgIf.tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long");

  property p_other_no_clock;
    protocolSelect != PROTO_DIV4 && protocolSelect != PROTO_DIRECT
      ##1 protocolSelect != PROTO_DIV4 && protocolSelect != PROTO_DIRECT |=> !linkClock;
  endproperty
  a_other_no_clock: assert property (p_other_no_clock) else $error("stray clock");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    property p_ena_alias;
      r.dataPhase && r.dataWrite && r.dataAddr == OFF_ENA + 8'(g * 4) && unlocked
        |=> linkEnable[g] == $past(hwdata[0]) && r.channel_input_control[g][ENA_BIT] == $past(hwdata[0]);
    endproperty
    a_ena_alias: assert property (p_ena_alias) else $error("enable alias broken");

    property p_no_start_disabled;
      transferStart[g] |-> $past(linkEnable[g]);
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled)
      else $error("start while disabled");

    property p_zero_delay;
      r.chState[g] == CH_IDLE && linkEnable[g] && edgeHit && delay == 8'h00
        |=> transferStart[g];
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay start missed");

    property p_start_cause;
      transferStart[g] |-> $past(r.chState[g] == CH_IDLE && delay == 8'h00 && edgeHit)
        || $past(r.chState[g] == CH_WAIT && cfgIf.tick && r.chCnt[g] == 8'h01);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without cause");

    property p_fall_phase;
      !r.ctrl[SRC_BIT] && r.ctrl[EDGE_BIT] && delay == 8'h00 && linkEnable[g]
        && r.chState[g] == CH_IDLE && r.prevPhase && !phaseClock |=> transferStart[g];
    endproperty
    a_fall_phase: assert property (p_fall_phase) else $error("falling edge missed");

    property p_phase_ignores_servo;
      !r.ctrl[SRC_BIT] && r.chState[g] == CH_IDLE && phaseClock == r.prevPhase
        |=> !transferStart[g];
    endproperty
    a_phase_ignores_servo: assert property (p_phase_ignores_servo)
      else $error("wrong source started");

    property p_channel_input_control_alias;
      r.dataPhase && r.dataWrite && r.dataAddr == OFF_CHANNEL_INPUT_CONTROL + 8'(g * 4) && unlocked
        |=> linkEnable[g] == $past(hwdata[ENA_BIT]);
    endproperty
    a_channel_input_control_alias: assert property (p_channel_input_control_alias) else $error("enable view lost");

    // both paths to the enable bit must be shut while locked
    property p_ena_locked;
      r.dataPhase && r.dataWrite && !unlocked
        && (r.dataAddr == OFF_ENA + 8'(g * 4) || r.dataAddr == OFF_CHANNEL_INPUT_CONTROL + 8'(g * 4))
        |=> $stable(r.channel_input_control[g]);
    endproperty
    a_ena_locked: assert property (p_ena_locked) else $error("locked enable changed");

    property p_cmd_write;
      r.dataPhase && r.dataWrite && r.dataAddr == OFF_CMD + 8'(g * 4)
        |=> linkCommand[g] == $past(hwdata);
    endproperty
    a_cmd_write: assert property (p_cmd_write) else $error("command write lost");

    property p_wait_load;
      r.chState[g] == CH_IDLE && linkEnable[g] && edgeHit && delay != 8'h00
        |=> r.chState[g] == CH_WAIT && r.chCnt[g] == $past(delay) && !transferStart[g];
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("delay not loaded");

    property p_count_down;
      r.chState[g] == CH_WAIT && linkEnable[g] && cfgIf.tick && r.chCnt[g] != 8'h01
        |=> r.chState[g] == CH_WAIT && r.chCnt[g] == $past(r.chCnt[g]) - 8'h01;
    endproperty
    a_count_down: assert property (p_count_down) else $error("delay count skipped");

    property p_rise_servo;
      r.ctrl[SRC_BIT] && !r.ctrl[EDGE_BIT] && delay == 8'h00 && linkEnable[g]
        && r.chState[g] == CH_IDLE && !r.prevServo && servoClock |=> transferStart[g];
    endproperty
    a_rise_servo: assert property (p_rise_servo) else $error("servo edge missed");
  end

  c_unlock:  cover property (r.dataPhase && r.dataWrite && r.dataAddr == OFF_KEY
                             ##1 unlocked);
  c_delayed: cover property (r.chState[0] == CH_WAIT ##[1:300] transferStart[0]);
  c_locked:  cover property (r.dataPhase && r.dataWrite && r.dataAddr == OFF_CTRL && !unlocked);
  c_div4:    cover property (protocolSelect == PROTO_DIV4 && $rose(linkClock));
endmodule // setc_top

// [tb/setc_enc_model.sv]
`timescale 1ns/1ps
module setc_enc_model (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     srst,
  // link side
  input  wire logic                     linkClock,
  input  wire logic [setc_pkg::NCH-1:0] linkEnable,
  input  wire logic [setc_pkg::NCH-1:0] transferStart,
  // observation
  output logic                          stray
);
  import setc_pkg::*;
  // a frame request on a link that is switched off would hang the encoder
  always @(posedge clock) begin
    if (srst) begin
      stray <= 1'b0;
    end else if ((transferStart & ~linkEnable) !== '0) begin
      stray <= 1'b1;
    end
  end
endmodule // setc_enc_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import setc_pkg::*;
  logic                clock, srst, hwrite, hready, hreadyout, hresp, linkClock, stray;
  logic                phaseClock, servoClock;
  logic [1:0]          htrans;
  logic [31:0]         haddr, hwdata, hrdata, r, v;
  logic [NCH-1:0]      linkEnable, transferStart;
  logic [NCH-1:0][31:0] linkCommand;
  logic [7:0]          protocolSelect;
  int                  bad_count, num_checks;

  assign hready = hreadyout;
  setc_top dut_u (.clock(clock), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phaseClock(phaseClock),
    .servoClock(servoClock), .linkClock(linkClock), .linkEnable(linkEnable),
    .transferStart(transferStart), .linkCommand(linkCommand),
    .protocolSelect(protocolSelect));
  setc_enc_model enc_u (.clock(clock), .srst(srst), .linkClock(linkClock),
    .linkEnable(linkEnable), .transferStart(transferStart), .stray(stray));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(a, 1'b0, 32'h00000000, x);
    chk(x, exp);
  endtask

  // unselected clock moves first, so a wrong source select shows as an early pulse
  task automatic trig(input logic [7:0] m, input logic [3:0] e, input logic s, input logic g,
                      input logic [7:0] d, input logic [NCH-1:0] ena);
    int p, c, lim, lo, hi;
    p = (m + 1) << e;
    lim = d * p + p + 3;
    // first tick after the edge may come anywhere within one tick period
    lo = (d == 0) ? 2 : (d - 1) * p + 3;
    hi = d * p + 2;
    wr(OFF_CTRL, {m, e, 2'b00, s, g, d, PROTO_DIRECT});
    phaseClock <= g;
    servoClock <= g;
    c = 0;
    repeat (lim + 8) begin
      @(posedge clock);
      if (transferStart !== '0) c++;
    end
    if (s) phaseClock <= !g;
    else servoClock <= !g;
    repeat (lim + 4) begin
      @(posedge clock);
      if (transferStart !== '0) c++;
    end
    chk(c, 0);
    if (s) servoClock <= !g;
    else phaseClock <= !g;
    c = 0;
    while (transferStart === '0 && c < lim + 20) begin
      @(posedge clock);
      c++;
    end
    chk(transferStart, ena);
    if (ena != '0) chk(c >= lo && c <= hi, 1);
    @(posedge clock);
    chk(transferStart, '0);
  endtask

  task automatic lk(input logic [7:0] m, input logic [3:0] e, input logic [7:0] pr,
                    input int cyc, input int hi);
    int c;
    wr(OFF_CTRL, {m, e, 12'h000, pr});
    repeat (300) @(posedge clock);
    chk(protocolSelect, pr);
    c = 0;
    repeat (cyc) begin
      @(posedge clock);
      if (linkClock === 1'b1) c++;
    end
    chk(c, hi);
  endtask

  initial begin
    #(10 * 90000);
    bad_count++;
    final_report();
  end

  initial begin
    srst = 1'b1;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    phaseClock = 1'b0;
    servoClock = 1'b0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(32'h51DED56A));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rdchk(OFF_CTRL, CTRL_RESET);
    for (int j = 0; j < NCH; j++) begin
      rdchk(OFF_ENA + j * CH_STRIDE, 32'h00000000);
      rdchk(OFF_CHANNEL_INPUT_CONTROL + j * CH_STRIDE, 32'h00000000);
      rdchk(OFF_CMD + j * CH_STRIDE, 32'h00000000);
    end
    chk(linkEnable, '0);
    // still locked: both protected paths must hold
    wr(OFF_CTRL, $urandom());
    wr(OFF_ENA, 32'h00000001);
    rdchk(OFF_CTRL, CTRL_RESET);
    chk(linkEnable, '0);
    wr(OFF_KEY, UNLOCK_KEY);
    rdchk(OFF_STAT, 32'h00000001);
    v = $urandom() & 32'hFFF3FFFF;
    wr(OFF_CTRL, v);
    rdchk(OFF_CTRL, v);
    chk(protocolSelect, v[7:0]);
    wr(OFF_ENA, 32'h00000001);
    rdchk(OFF_CHANNEL_INPUT_CONTROL, 32'h00100000);
    wr(OFF_CHANNEL_INPUT_CONTROL + 2 * CH_STRIDE, 32'h00100000);
    rdchk(OFF_ENA + 2 * CH_STRIDE, 32'h00000001);
    chk(linkEnable, 4'h5);
    for (int j = 0; j < NCH; j++) begin
      v = $urandom();
      wr(OFF_CMD + j * CH_STRIDE, v);
      rdchk(OFF_CMD + j * CH_STRIDE, v);
      chk(linkCommand[j], v);
    end
    rdchk(8'hFC, 32'h00000000);
    trig(8'h00, 4'h0, 1'b0, 1'b0, 8'hFF, 4'h5);
    trig(8'h02, 4'h1, 1'b1, 1'b1, 8'h03, 4'h5);
    for (int k = 0; k < 8; k++) begin
      trig($urandom_range(0, 3), $urandom_range(0, 2), k[0], k[1], $urandom_range(0, 7), 4'h5);
    end
    lk(8'h01, 4'h1, PROTO_DIRECT, 40, 20);
    lk(8'h01, 4'h0, PROTO_DIV4, 100, 52);
    lk(8'h00, 4'h0, PROTO_BUILTIN, 100, 0);
    wr(OFF_CHANNEL_INPUT_CONTROL, 32'h00000000);
    wr(OFF_ENA + 2 * CH_STRIDE, 32'h00000000);
    trig(8'h00, 4'h0, 1'b0, 1'b0, 8'h01, 4'h0);
    r = $urandom() & 32'hFFF3FFFF;
    wr(OFF_CTRL, r);
    wr(OFF_KEY, 32'h00000000);
    wr(OFF_CTRL, ~r);
    rdchk(OFF_CTRL, r);
    rdchk(OFF_STAT, 32'h00000000);
    chk(stray, 1'b0);
    final_report();
  end
endmodule // testbench
